// >>> logic/configurable_logic.sv
// two-table configurable logic block with sequencer, filters and APB registers
//
// Local design decision: register access over APB.
`timescale 1ns/10ps

// How it works
// - gated D flop: D even, G odd
// - JK flop: J even, K odd, toggle
// - D latch transparent while odd gate high
// - RS latch: set even, reset odd; both forbidden
// - sequencer codes: off, DFF, JK, latch, RS
// - each table output is an output event
// - selected event level feeds truth input directly
// - run-in-standby keeps peripheral clock requested
// - standby without run-in-standby forces clocked outputs low
// - idle sleep keeps truth tables evaluating
// - clock source bit selects input 2 clock
// - sequencer clocked by even table's clock
// - filter codes: none, synchronizer, glitch filter
// - output enable drives table output to pin
// - global enable bit 0, run-in-standby bit 6
// - control A bit 7 enables rising-edge detector
// - control A bit 0 enables each table
// - run-in-standby ignored when no clock needed
// - output is truth bit indexed by inputs
// - even table disable clears sequencer
// - protected fields writable only while disabled
// - filter delays two or four; cleared after disable
module configurable_logic (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [5:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic STANDBY,
    input wire logic [3:0] LUT_EVENT_INPUT,
    input wire logic [5:0] PIN_IN,
    input wire logic [35:0] PERIPH_IN,
    output logic [1:0] LUT_OUTPUT_EVENT,
    output logic [1:0] PIN_OUT,
    output logic [1:0] PIN_OE,
    output logic PERIPHERAL_CLOCK_REQUEST
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] global_control_ff;
    logic [7:0] sequencer_select_ff;
    logic [7:0] control_a_ff [2];
    logic [7:0] select_low_ff [2];
    logic [7:0] select_high_ff [2];
    logic [7:0] truth_ff [2];

    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [1:0] out_ff;
    logic [1:0] oe_ff;
    logic clk_req_ff;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire [3:0] idx = PADDR[5:2];
    wire setup_phase = PSEL & ~PENABLE;
    wire write_strobe = PSEL & PENABLE & pready_ff & PWRITE;
    wire [7:0] wdata = PWDATA[7:0];
    wire hit_global = (idx == configurable_logic_pkg::IDX_GLOBAL);
    wire hit_seq = (idx == configurable_logic_pkg::IDX_SEQ);
    wire global_enable = global_control_ff[configurable_logic_pkg::GC_ENABLE_BIT];
    wire run_in_standby = global_control_ff[configurable_logic_pkg::GC_RUN_IN_STANDBY_BIT];

    logic [1:0] hit_ctrl_a;
    logic [1:0] hit_sel_low;
    logic [1:0] hit_sel_high;
    logic [1:0] hit_truth;
    logic [1:0] lut_enabled;
    logic [1:0] own_enable_bit;
    logic [1:0] tick;
    logic [1:0] truth_out;
    logic [1:0] stage_out;
    logic [1:0] clocked_use;
    logic [2:0] lut_in [2];
    logic [7:0] rd_lut [2];
    logic [1:0] rd_hit;

    // ----------------------------------------
    // sequencer wires
    // ----------------------------------------
    logic seq_q_ff;
    logic nxt_seq_q;
    wire [3:0] seq_mode = sequencer_select_ff[3:0];
    wire seq_known = (seq_mode == configurable_logic_pkg::SEQ_GATED_D_FLOP) |
                     (seq_mode == configurable_logic_pkg::SEQ_JK_FLOP) |
                     (seq_mode == configurable_logic_pkg::SEQ_GATED_D_LATCH) |
                     (seq_mode == configurable_logic_pkg::SEQ_RS_LATCH);
    wire seq_active = seq_known & lut_enabled[0];

    // ----------------------------------------
    // input source selection
    // ----------------------------------------
    function automatic logic pick_source(
        input logic [3:0] code,
        input logic feedback,
        input logic link,
        input logic event_a,
        input logic event_b,
        input logic pin,
        input logic [5:0] periph
    );
        logic [3:0] offs;
        logic r;
        offs = code - configurable_logic_pkg::INSRC_PERIPH_FIRST;
        r = 1'b0;
        unique case (code)
            configurable_logic_pkg::INSRC_MASK: r = 1'b0;
            configurable_logic_pkg::INSRC_FEEDBACK: r = feedback;
            configurable_logic_pkg::INSRC_LINK: r = link;
            configurable_logic_pkg::INSRC_EVENT_A: r = event_a;
            configurable_logic_pkg::INSRC_EVENT_B: r = event_b;
            configurable_logic_pkg::INSRC_PIN: r = pin;
            default: begin
                if (code <= configurable_logic_pkg::INSRC_PERIPH_LAST) begin
                    r = periph[offs[2:0]];
                end else begin
                    r = 1'b0;
                end
            end
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // per-table datapath
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lut
            wire [7:0] ca = control_a_ff[gi];
            wire [1:0] filt_sel = ca[configurable_logic_pkg::CA_FILTER_LSB +: 2];
            wire edge_en = ca[configurable_logic_pkg::CA_EDGE_DETECT_BIT];
            wire clk_src = ca[configurable_logic_pkg::CA_CLOCK_SOURCE_BIT];
            wire [3:0] idx_a = configurable_logic_pkg::IDX_LUT0_CTRL_A +
                               4'(gi) * configurable_logic_pkg::IDX_LUT_STRIDE;
            wire [3:0] idx_l = configurable_logic_pkg::IDX_LUT0_SEL_LOW +
                               4'(gi) * configurable_logic_pkg::IDX_LUT_STRIDE;
            wire [3:0] idx_h = configurable_logic_pkg::IDX_LUT0_SEL_HIGH +
                               4'(gi) * configurable_logic_pkg::IDX_LUT_STRIDE;
            wire [3:0] idx_t = configurable_logic_pkg::IDX_LUT0_TRUTH +
                               4'(gi) * configurable_logic_pkg::IDX_LUT_STRIDE;
            // link reads the other table's registered output, so two tables
            // linked to each other cannot form a combinational loop
            wire link_bit = out_ff[1 - gi];
            logic in2_prev_ff;
            logic en_delay_ff;
            logic sync1_ff;
            logic sync2_ff;
            logic sync3_ff;
            logic glitch_ff;
            logic edge_prev_ff;
            logic filt_out;
            wire filter_clear = ~en_delay_ff;

            assign hit_ctrl_a[gi] = (idx == idx_a);
            assign hit_sel_low[gi] = (idx == idx_l);
            assign hit_sel_high[gi] = (idx == idx_h);
            assign hit_truth[gi] = (idx == idx_t);
            assign own_enable_bit[gi] = ca[configurable_logic_pkg::CA_ENABLE_BIT];
            assign lut_enabled[gi] = own_enable_bit[gi] & global_enable;

            // event slots: inputs 0/1 use events gi and gi+2, input 2 uses 0 and 1
            assign lut_in[gi][0] = pick_source(select_low_ff[gi][3:0], seq_q_ff, link_bit,
                LUT_EVENT_INPUT[gi], LUT_EVENT_INPUT[gi + 2], PIN_IN[gi * 3],
                PERIPH_IN[(gi * 3) * 6 +: 6]);
            assign lut_in[gi][1] = pick_source(select_low_ff[gi][7:4], seq_q_ff, link_bit,
                LUT_EVENT_INPUT[gi], LUT_EVENT_INPUT[gi + 2], PIN_IN[gi * 3 + 1],
                PERIPH_IN[(gi * 3 + 1) * 6 +: 6]);
            assign lut_in[gi][2] = pick_source(select_high_ff[gi][3:0], seq_q_ff, link_bit,
                LUT_EVENT_INPUT[0], LUT_EVENT_INPUT[1], PIN_IN[gi * 3 + 2],
                PERIPH_IN[(gi * 3 + 2) * 6 +: 6]);

            // truth evaluation is combinational and never waits for a clock
            assign truth_out[gi] = truth_ff[gi][lut_in[gi]];

            // input 2 as clock: a rising edge of it is one clocking step
            assign tick[gi] = clk_src ? (lut_in[gi][2] & ~in2_prev_ff) : 1'b1;

            always_comb begin
                unique case (filt_sel)
                    configurable_logic_pkg::FILT_SYNCHRONIZER: filt_out = sync2_ff;
                    configurable_logic_pkg::FILT_GLITCH: filt_out = glitch_ff;
                    default: filt_out = truth_out[gi];
                endcase
            end

            assign stage_out[gi] = edge_en ? (filt_out & ~edge_prev_ff) : filt_out;
            assign clocked_use[gi] = lut_enabled[gi] &
                ((filt_sel == configurable_logic_pkg::FILT_SYNCHRONIZER) |
                 (filt_sel == configurable_logic_pkg::FILT_GLITCH) | edge_en);

            always_ff @(posedge CLK) begin
                if (RST) begin
                    in2_prev_ff <= 1'b0;
                    en_delay_ff <= 1'b0;
                end else begin
                    in2_prev_ff <= lut_in[gi][2];
                    en_delay_ff <= lut_enabled[gi];
                end
            end

            // synchronizer gives two steps of delay, the glitch filter four
            always_ff @(posedge CLK) begin
                if (RST || filter_clear) begin
                    sync1_ff <= 1'b0;
                    sync2_ff <= 1'b0;
                    sync3_ff <= 1'b0;
                    glitch_ff <= 1'b0;
                    edge_prev_ff <= 1'b0;
                end else if (tick[gi]) begin
                    sync1_ff <= truth_out[gi];
                    sync2_ff <= sync1_ff;
                    sync3_ff <= sync2_ff;
                    glitch_ff <= (sync2_ff == sync3_ff) ? sync3_ff : glitch_ff;
                    edge_prev_ff <= filt_out;
                end
            end

            assign rd_lut[gi] = ({8{hit_ctrl_a[gi]}} & control_a_ff[gi]) |
                                ({8{hit_sel_low[gi]}} & select_low_ff[gi]) |
                                ({8{hit_sel_high[gi]}} & select_high_ff[gi]) |
                                ({8{hit_truth[gi]}} & truth_ff[gi]);
            assign rd_hit[gi] = hit_ctrl_a[gi] | hit_sel_low[gi] | hit_sel_high[gi] |
                                hit_truth[gi];
        end
    endgenerate

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            global_control_ff <= configurable_logic_pkg::REG_RESET;
            sequencer_select_ff <= configurable_logic_pkg::REG_RESET;
        end else if (write_strobe) begin
            if (hit_global) begin
                global_control_ff <= wdata & configurable_logic_pkg::GLOBAL_MASK;
            end
            if (hit_seq && !own_enable_bit[0]) begin
                sequencer_select_ff <= wdata & configurable_logic_pkg::SEQ_MASK;
            end
        end
    end

    // while a table runs only its enable bit moves; when it is off the whole
    // register loads, which also covers setting fields and enable together
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < 2; i++) begin
                control_a_ff[i] <= configurable_logic_pkg::REG_RESET;
                select_low_ff[i] <= configurable_logic_pkg::REG_RESET;
                select_high_ff[i] <= configurable_logic_pkg::REG_RESET;
                truth_ff[i] <= configurable_logic_pkg::REG_RESET;
            end
        end else if (write_strobe) begin
            for (int i = 0; i < 2; i++) begin
                if (hit_ctrl_a[i]) begin
                    if (own_enable_bit[i]) begin
                        control_a_ff[i][configurable_logic_pkg::CA_ENABLE_BIT] <=
                            wdata[configurable_logic_pkg::CA_ENABLE_BIT];
                    end else begin
                        control_a_ff[i] <= wdata & configurable_logic_pkg::CTRL_A_MASK;
                    end
                end
                if (hit_sel_low[i] && !own_enable_bit[i]) begin
                    select_low_ff[i] <= wdata;
                end
                if (hit_sel_high[i] && !own_enable_bit[i]) begin
                    select_high_ff[i] <= wdata & configurable_logic_pkg::SEL_HIGH_MASK;
                end
                if (hit_truth[i] && !own_enable_bit[i]) begin
                    truth_ff[i] <= wdata;
                end
            end
        end
    end

    // ----------------------------------------
    // sequential element
    // ----------------------------------------
    // latch modes are sampled on every clock step rather than built as real
    // latches, which keeps the block free of level-sensitive storage
    always_comb begin
        nxt_seq_q = seq_q_ff;
        unique case (seq_mode)
            configurable_logic_pkg::SEQ_GATED_D_FLOP: begin
                if (stage_out[1]) begin
                    nxt_seq_q = stage_out[0];
                end
            end
            configurable_logic_pkg::SEQ_JK_FLOP: begin
                unique case ({stage_out[0], stage_out[1]})
                    2'b01: nxt_seq_q = 1'b0;
                    2'b10: nxt_seq_q = 1'b1;
                    2'b11: nxt_seq_q = ~seq_q_ff;
                    default: nxt_seq_q = seq_q_ff;
                endcase
            end
            configurable_logic_pkg::SEQ_GATED_D_LATCH: begin
                if (stage_out[1]) begin
                    nxt_seq_q = stage_out[0];
                end
            end
            configurable_logic_pkg::SEQ_RS_LATCH: begin
                // both high is forbidden; holding is the harmless answer
                unique case ({stage_out[0], stage_out[1]})
                    2'b10: nxt_seq_q = 1'b1;
                    2'b01: nxt_seq_q = 1'b0;
                    default: nxt_seq_q = seq_q_ff;
                endcase
            end
            default: nxt_seq_q = 1'b0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST || !lut_enabled[0]) begin
            seq_q_ff <= 1'b0;
        end else if (tick[0]) begin
            seq_q_ff <= nxt_seq_q;
        end
    end

    // ----------------------------------------
    // outputs, standby and clock request
    // ----------------------------------------
    wire [1:0] src_in2 = {control_a_ff[1][configurable_logic_pkg::CA_CLOCK_SOURCE_BIT],
                          control_a_ff[0][configurable_logic_pkg::CA_CLOCK_SOURCE_BIT]};
    wire clock_needed = (|(clocked_use & ~src_in2)) | (seq_active & ~src_in2[0]);
    wire standby_force = STANDBY & ~run_in_standby;
    wire [1:0] clocked_path = {clocked_use[1], clocked_use[0] | seq_active};
    wire [1:0] pre_out = {stage_out[1], seq_active ? seq_q_ff : stage_out[0]};
    wire [1:0] final_out = pre_out & lut_enabled & ~({2{standby_force}} & clocked_path);
    wire [1:0] pin_drive = {control_a_ff[1][configurable_logic_pkg::CA_PIN_OUTPUT_ENABLE_BIT],
                            control_a_ff[0][configurable_logic_pkg::CA_PIN_OUTPUT_ENABLE_BIT]}
                           & lut_enabled;

    always_ff @(posedge CLK) begin
        if (RST) begin
            out_ff <= 2'h0;
            oe_ff <= 2'h0;
            clk_req_ff <= 1'b0;
        end else begin
            out_ff <= final_out;
            oe_ff <= pin_drive;
            // no request at all when only combinational paths are in use
            clk_req_ff <= clock_needed & (~STANDBY | run_in_standby);
        end
    end

    assign LUT_OUTPUT_EVENT = out_ff;
    assign PIN_OUT = out_ff;
    assign PIN_OE = oe_ff;
    assign PERIPHERAL_CLOCK_REQUEST = clk_req_ff;

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    wire mapped = hit_global | hit_seq | (|rd_hit);
    wire [7:0] rd_byte = ({8{hit_global}} & global_control_ff) |
                         ({8{hit_seq}} & sequencer_select_ff) | rd_lut[0] | rd_lut[1];

    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase & ~mapped;
            prdata_ff <= (setup_phase & ~PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign PRDATA = prdata_ff;

endmodule

// >>> include/configurable_logic_pkg.sv
// constants for the two-table configurable logic block
package configurable_logic_pkg;

    // ----------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------
    localparam logic [3:0] IDX_GLOBAL = 4'h0;
    localparam logic [3:0] IDX_SEQ = 4'h1;
    localparam logic [3:0] IDX_LUT0_CTRL_A = 4'h5;
    localparam logic [3:0] IDX_LUT0_SEL_LOW = 4'h6;
    localparam logic [3:0] IDX_LUT0_SEL_HIGH = 4'h7;
    localparam logic [3:0] IDX_LUT0_TRUTH = 4'h8;
    localparam logic [3:0] IDX_LUT1_CTRL_A = 4'h9;
    localparam logic [3:0] IDX_LUT1_SEL_LOW = 4'hA;
    localparam logic [3:0] IDX_LUT1_SEL_HIGH = 4'hB;
    localparam logic [3:0] IDX_LUT1_TRUTH = 4'hC;
    localparam logic [3:0] IDX_LUT_STRIDE = 4'h4;

    // ----------------------------------------
    // reset values and writable masks
    // ----------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] GLOBAL_MASK = 8'h41;
    localparam logic [7:0] SEQ_MASK = 8'h0F;
    localparam logic [7:0] CTRL_A_MASK = 8'hF9;
    localparam logic [7:0] SEL_HIGH_MASK = 8'h0F;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int GC_ENABLE_BIT = 0;
    localparam int GC_RUN_IN_STANDBY_BIT = 6;
    localparam int CA_ENABLE_BIT = 0;
    localparam int CA_PIN_OUTPUT_ENABLE_BIT = 3;
    localparam int CA_FILTER_LSB = 4;
    localparam int CA_CLOCK_SOURCE_BIT = 6;
    localparam int CA_EDGE_DETECT_BIT = 7;

    // ----------------------------------------
    // sequencer_select_field codes
    // ----------------------------------------
    localparam logic [3:0] SEQ_OFF = 4'h0;
    localparam logic [3:0] SEQ_GATED_D_FLOP = 4'h1;
    localparam logic [3:0] SEQ_JK_FLOP = 4'h2;
    localparam logic [3:0] SEQ_GATED_D_LATCH = 4'h3;
    localparam logic [3:0] SEQ_RS_LATCH = 4'h4;

    // ----------------------------------------
    // output_filter_select codes
    // ----------------------------------------
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_SYNCHRONIZER = 2'h1;
    localparam logic [1:0] FILT_GLITCH = 2'h2;

    // ----------------------------------------
    // input source codes
    // ----------------------------------------
    localparam logic [3:0] INSRC_MASK = 4'h0;
    localparam logic [3:0] INSRC_FEEDBACK = 4'h1;
    localparam logic [3:0] INSRC_LINK = 4'h2;
    localparam logic [3:0] INSRC_EVENT_A = 4'h3;
    localparam logic [3:0] INSRC_EVENT_B = 4'h4;
    localparam logic [3:0] INSRC_PIN = 4'h5;
    localparam logic [3:0] INSRC_PERIPH_FIRST = 4'h6;
    localparam logic [3:0] INSRC_PERIPH_LAST = 4'hB;
    localparam int PERIPH_PER_INPUT = 6;

endpackage

// >>> tb/configurable_logic_properties.sv
// port-level assertions for the configurable logic block
`timescale 1ns/10ps
module configurable_logic_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [5:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic STANDBY,
    input wire logic [1:0] LUT_OUTPUT_EVENT,
    input wire logic [1:0] PIN_OUT,
    input wire logic [1:0] PIN_OE,
    input wire logic PERIPHERAL_CLOCK_REQUEST
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // -----------------------------
    // shadow of run-in-standby and global enable
    // -----------------------------
    logic [1:0] glob_ff;
    wire glob_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR[5:2] == 4'h0;
    always_ff @(posedge CLK) begin
        glob_ff <= RST ? 2'h0 : (glob_wr ? {PWDATA[6], PWDATA[0]} : glob_ff);
    end
    a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready in the access cycle");
    a_ready_one_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held past one cycle");
    a_err_with_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error without ready or with data");
    a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside an answer");
    a_pin_mirrors: assert property (PIN_OUT == LUT_OUTPUT_EVENT)
        else $error("pin value differs from table output");
    a_reset_clears: assert property ($fell(RST) |-> LUT_OUTPUT_EVENT == 2'h0
        && PIN_OE == 2'h0 && !PERIPHERAL_CLOCK_REQUEST)
        else $error("outputs not cleared by reset");
    a_global_off_quiet: assert property (!glob_ff[0] ##1 !glob_ff[0]
        |-> LUT_OUTPUT_EVENT == 2'h0 && PIN_OE == 2'h0)
        else $error("output active while block disabled");
    a_standby_no_clock: assert property (STANDBY && !glob_ff[1] ##1 STANDBY && !glob_ff[1]
        |-> !PERIPHERAL_CLOCK_REQUEST)
        else $error("clock requested in standby");
endmodule

bind configurable_logic configurable_logic_properties chk_u (.CLK, .RST, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .STANDBY, .LUT_OUTPUT_EVENT,
    .PIN_OUT, .PIN_OE, .PERIPHERAL_CLOCK_REQUEST);

// >>> tb/logic_sources.sv
// far-side model: event, pin and peripheral levels feeding the tables
`timescale 1ns/10ps
module logic_sources (
    input wire logic clk,
    input wire logic slow,
    input wire logic [3:0] lvl,
    output logic [3:0] events,
    output logic [5:0] pins,
    output logic [35:0] periph
);
    logic [3:0] stage_ff;
    logic [3:0] out_ff;
    // slow mode answers a cycle later, as a distant event channel would
    always_ff @(posedge clk) begin
        stage_ff <= lvl;
        out_ff <= slow ? stage_ff : lvl;
    end
    assign events = out_ff;
    // unselected sources toggle against the events so a wrong source shows
    assign pins = {~out_ff[1:0], ~out_ff};
    assign periph = {9{~out_ff}};
endmodule

// >>> tb/tb_configurable_logic.sv
// self-checking bench for the configurable logic block
`timescale 1ns/10ps
module tb_configurable_logic;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [5:0] PADDR = 6'h00;
    logic [31:0] PWDATA = 32'h0;
    logic STANDBY = 1'b0;
    logic slow = 1'b0;
    logic [3:0] lvl = 4'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, PERIPHERAL_CLOCK_REQUEST;
    logic [3:0] events;
    logic [5:0] pins;
    logic [35:0] periph;
    logic [1:0] LUT_OUTPUT_EVENT, PIN_OUT, PIN_OE;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    // rows: truth, event levels, expected even output
    logic [12:0] rows [5] = '{{8'hAA, 4'h1, 1'b1}, {8'h80, 4'h7, 1'b1}, {8'h80, 4'h6, 1'b0},
        {8'h10, 4'h2, 1'b1}, {8'h04, 4'h4, 1'b1}};
    // sequencer rows: mode, three event levels, three expected outputs
    logic [18:0] seqs [5] = '{{4'h1, 12'h312, 3'b110}, {4'h2, 12'h102, 3'b110},
        {4'h3, 12'h312, 3'b110}, {4'h4, 12'h102, 3'b110}, {4'h5, 12'h102, 3'b100}};
    always #2.5 CLK = ~CLK;
    logic_sources src_u (.clk(CLK), .slow(slow), .lvl(lvl), .events(events), .pins(pins),
        .periph(periph));
    configurable_logic dut_u (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .STANDBY, .LUT_EVENT_INPUT(events), .PIN_IN(pins),
        .PERIPH_IN(periph), .LUT_OUTPUT_EVENT, .PIN_OUT, .PIN_OE, .PERIPHERAL_CLOCK_REQUEST);
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= {idx, 2'b00};
        PWDATA <= {24'h0, wd};
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        check("read data", {24'h0, exp}, r);
        check("slave error", {31'h0, experr}, {31'h0, e});
    endtask
    // levels settle through the model, the inputs and the output register
    task automatic step(input logic [3:0] l, input logic exp, input string what);
        lvl <= l;
        repeat (6) @(posedge CLK);
        check(what, {31'h0, exp}, {31'h0, LUT_OUTPUT_EVENT[0]});
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 5000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < 14; i++) rd(i[3:0], 8'h00, i inside {2, 3, 4, 13});
        $display("test register defaults done");
        wr(configurable_logic_pkg::IDX_GLOBAL, 8'h01);
        wr(configurable_logic_pkg::IDX_LUT0_SEL_LOW, 8'h43);
        wr(configurable_logic_pkg::IDX_LUT0_SEL_HIGH, 8'h04);
        for (int i = 0; i < 5; i++) begin
            wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h00);
            wr(configurable_logic_pkg::IDX_LUT0_TRUTH, rows[i][12:5]);
            wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h01);
            step(rows[i][4:1], rows[i][0], "table output");
        end
        $display("test truth rows done");
        wr(configurable_logic_pkg::IDX_LUT0_TRUTH, 8'hFF);
        wr(configurable_logic_pkg::IDX_SEQ, 8'h02);
        wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h31);
        rd(configurable_logic_pkg::IDX_LUT0_TRUTH, 8'h04, 1'b0);
        rd(configurable_logic_pkg::IDX_SEQ, 8'h00, 1'b0);
        rd(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h01, 1'b0);
        $display("test protection done");
        wr(configurable_logic_pkg::IDX_LUT1_SEL_LOW, 8'h03);
        wr(configurable_logic_pkg::IDX_LUT1_TRUTH, 8'hAA);
        wr(configurable_logic_pkg::IDX_LUT1_CTRL_A, 8'h01);
        // set and reset never high together in the latch row
        for (int i = 0; i < 5; i++) begin
            wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h00);
            wr(configurable_logic_pkg::IDX_SEQ, {4'h0, seqs[i][18:15]});
            wr(configurable_logic_pkg::IDX_LUT0_TRUTH, 8'hAA);
            wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h01);
            for (int j = 0; j < 3; j++) begin
                step(seqs[i][14-4*j -: 4], seqs[i][2-j], "seq out");
                check("odd out", {31'h0, seqs[i][12-4*j]}, {31'h0, LUT_OUTPUT_EVENT[1]});
            end
        end
        $display("test sequencer modes done");
        slow <= 1'b1;
        wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h00);
        wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h19);
        step(4'h1, 1'b1, "filtered output");
        check("pin drive", 32'h1, {31'h0, PIN_OE[0]});
        STANDBY <= 1'b1;
        step(4'h1, 1'b0, "standby output");
        check("clock request", 32'h0, {31'h0, PERIPHERAL_CLOCK_REQUEST});
        wr(configurable_logic_pkg::IDX_GLOBAL, 8'h41);
        step(4'h1, 1'b1, "run in standby");
        check("clock request", 32'h1, {31'h0, PERIPHERAL_CLOCK_REQUEST});
        STANDBY <= 1'b0;
        wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h00);
        wr(configurable_logic_pkg::IDX_LUT0_CTRL_A, 8'h91);
        step(4'h1, 1'b0, "edge pulse end");
        $display("test standby done");
        summarize();
    end
endmodule
